/* File: hdl/sdf_filter_top.sv */
// sinc3 decimator with comparator, counters and accumulator for the current channel
`include "sdf_consts.svh"

// Overview of operation
// - mode register bits 4:3 pick normal, low power or low power plus.
// - low power plus forces amplifier gain to 512 whatever is programmed.
// - counter, comparator and accumulator keep working in both low power modes.
// - mode register bit 5 picks precision or low power reference.
// - comparator mode raises interrupt when result magnitude exceeds threshold.
// - extended mode counts threshold hits; interrupt when count reaches limit.
// - result counter enabled gates interrupt until limit conversions have completed.
// - 32-bit accumulator adds or subtracts results, set by config bits 6:5, readable.
// - one 16-bit filter register sets common sinc3 response for all channels.
// - decimation factor in bits 6:0, averaging factor in bits 13:8.
// - filter register resets to 0x0007, giving 1 kHz with options off.
// - sinc3 modify bit adds a second notch near 1.333 times first notch.
// - filter register 0x0000 gives maximum 8 kHz rate in normal mode.
// - running average bit averages each output with predecessor, same rate.
// - bit 15 enables chop; 0x1F/0x16 with chop gives about 10.9 Hz.
// - chop with 0x1D/0x3F gives about 4.2 Hz; 0x7F/0x3F gives the minimum normal rate, about 1 Hz.
// - low power mode clocks modulator at 131 kHz, rate about four times lower.
// - threshold counter increments at or above threshold, decrements or clears below.
// - result counter wraps at limit and clears when config or mode written.
// - low power mode forces amplifier gain to 128.
// - accumulator clears when disabled or when channel is reconfigured.
module sdf_filter_top #(
    parameter int DATA_W = 24
) (
    // clock, reset, enable
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic i_CE,
    // register port
    input wire logic [3:0] i_ADDR,
    input wire logic [31:0] i_WDATA,
    input wire logic i_WR,
    input wire logic i_RD,
    output logic [31:0] o_RDATA,
    // modulator bit stream, one bit per strobe
    input wire logic i_MOD_BIT,
    input wire logic i_MOD_STB,
    // analog control and result
    output sdf_pkg::sdf_pwr_t o_PWR_MODE,
    output logic o_REF_LOWPOWER,
    output logic o_LP_CLK_SEL,
    output logic [9:0] o_GAIN,
    input wire logic [9:0] i_GAIN_PROG,
    output logic [15:0] o_RESULT,
    output logic o_RESULT_VLD,
    output logic o_IRQ
);
    import sdf_pkg::*;

    // ************************************************************
    // registers
    // ************************************************************
    logic [15:0] filter_cfg;
    logic [7:0] mode_reg;
    logic [7:0] feature_cfg;
    logic [15:0] thresh;
    logic [7:0] tcl;
    logic [7:0] thv;
    logic [31:0] acc;
    logic [15:0] rcl;
    logic [15:0] rcv;
    logic [3:0] status;

    // decode of the plain register port
    wire wr_filter = i_WR && i_ADDR == `SDF_OFF_FILTER;
    wire wr_mode = i_WR && i_ADDR == `SDF_OFF_MODE;
    wire wr_feature = i_WR && i_ADDR == `SDF_OFF_FEATURE;
    wire wr_thresh = i_WR && i_ADDR == `SDF_OFF_THRESH;
    wire wr_tcl = i_WR && i_ADDR == `SDF_OFF_TCL;
    wire wr_rcl = i_WR && i_ADDR == `SDF_OFF_RCL;
    wire wr_status = i_WR && i_ADDR == `SDF_OFF_STATUS;
    // writing mode or feature config counts as reconfiguring the channel
    wire reconfig = i_CE && (wr_mode || wr_feature);
    // a new filter setting also restarts the decimator, so the count never overshoots a shorter length
    wire restart = reconfig || (i_CE && wr_filter);

    wire [6:0] dec_factor = filter_cfg[`SDF_FLT_DEC_HI:`SDF_FLT_DEC_LO];
    wire [5:0] avg_factor = filter_cfg[`SDF_FLT_AVG_HI:`SDF_FLT_AVG_LO];
    wire sinc_mod = filter_cfg[`SDF_FLT_MOD];
    wire run_avg = filter_cfg[`SDF_FLT_RAVG];
    wire chop_en = filter_cfg[`SDF_FLT_CHOP];
    wire sdf_pwr_t pwr = sdf_pwr_t'(mode_reg[`SDF_MDE_PWR_HI:`SDF_MDE_PWR_LO]);
    wire sdf_cmp_t cmp_mode = sdf_cmp_t'(feature_cfg[`SDF_CFG_CMP_HI:`SDF_CFG_CMP_LO]);
    wire sdf_acc_t acc_mode = sdf_acc_t'(feature_cfg[`SDF_CFG_ACC_HI:`SDF_CFG_ACC_LO]);
    wire rc_en = feature_cfg[`SDF_CFG_RCEN];

    // register write process
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            filter_cfg <= `SDF_RST_FILTER;
            mode_reg <= `SDF_RST_MODE;
            feature_cfg <= `SDF_RST_FEATURE;
            thresh <= `SDF_RST_THRESH;
            tcl <= `SDF_RST_TCL;
            rcl <= `SDF_RST_RCL;
        end else if (i_CE) begin
            if (wr_filter) filter_cfg <= i_WDATA[15:0];
            if (wr_mode) mode_reg <= i_WDATA[7:0];
            if (wr_feature) feature_cfg <= i_WDATA[7:0];
            if (wr_thresh) thresh <= i_WDATA[15:0];
            if (wr_tcl) tcl <= i_WDATA[7:0];
            if (wr_rcl) rcl <= i_WDATA[15:0];
        end
    end

    // ************************************************************
    // sinc3 decimator
    // ************************************************************
    // decimation length: (sf+1)*64 modulator bits; sf=0 gives 8 kHz at 512 kHz
    function automatic logic [14:0] dec_len(input logic [6:0] sf);
        dec_len = 15'((16'(sf) + 16'd1) * 16'(`SDF_BASE_DEC));
    endfunction

    // magnitude of a signed result as unsigned 16 bits, no saturation; -32768 gives 0x8000
    function automatic logic [15:0] mag16(input logic [15:0] v);
        mag16 = v[15] ? 16'(-v) : v;
    endfunction

    logic signed [DATA_W-1:0] int1, int2, int3;
    logic signed [DATA_W-1:0] dif1, dif2, dif3, dly3;
    logic signed [DATA_W-1:0] alt1;
    logic [14:0] dec_cnt;
    logic [5:0] avg_cnt;
    logic signed [DATA_W+5:0] avg_sum;
    logic chop_phase;
    logic [15:0] prev_out;
    logic [15:0] res_hold;
    sdf_fsm_t fsm;

    wire signed [DATA_W-1:0] bit_val = i_MOD_BIT ? DATA_W'(1) : -DATA_W'(1);
    wire dec_done = dec_cnt == dec_len(dec_factor) - 15'd1;
    // three-stage differentiator; modify option adds a delayed copy and halves the sum for an extra notch
    wire signed [DATA_W-1:0] comb1 = int3 - dif1;
    wire signed [DATA_W-1:0] comb2 = comb1 - dif2;
    wire signed [DATA_W-1:0] comb3 = comb2 - dif3;
    wire signed [DATA_W-1:0] sinc_out = sinc_mod ? DATA_W'(((DATA_W+1)'(comb3) + (DATA_W+1)'(dly3)) >>> 1) : comb3;
    // chop flips the sign on alternate decimations so offset cancels in the average
    wire signed [DATA_W-1:0] chopped = (chop_en && chop_phase) ? -sinc_out : sinc_out;
    wire signed [DATA_W+5:0] avg_next = avg_sum + (DATA_W+6)'(chopped);
    wire avg_done = avg_cnt == avg_factor;
    wire [15:0] avg_res = 16'((avg_next / $signed((DATA_W+6)'(32'(avg_factor) + 1))) >>> (DATA_W - 16));
    wire [15:0] ravg_res = 16'(({avg_res[15], avg_res} + {prev_out[15], prev_out}) >>> 1);
    wire [15:0] final_res = run_avg ? ravg_res : avg_res;

    // integrators run on every modulator strobe
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST || restart) begin
            int1 <= '0;
            int2 <= '0;
            int3 <= '0;
        end else if (i_CE && i_MOD_STB) begin
            int1 <= int1 + bit_val;
            int2 <= int2 + int1;
            int3 <= int3 + int2;
        end
    end

    // decimation, averaging and output state machine
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST || restart) begin
            fsm <= SDF_ST_INTEG;
            dec_cnt <= '0;
            avg_cnt <= '0;
            avg_sum <= '0;
            dif1 <= '0;
            dif2 <= '0;
            dif3 <= '0;
            dly3 <= '0;
            chop_phase <= 1'b0;
            prev_out <= '0;
            res_hold <= '0;
            o_RESULT_VLD <= 1'b0;
        end else if (i_CE) begin
            o_RESULT_VLD <= 1'b0;
            unique case (fsm)
                SDF_ST_INTEG: begin
                    if (i_MOD_STB) begin
                        dec_cnt <= dec_done ? 15'd0 : dec_cnt + 15'd1;
                        if (dec_done) fsm <= SDF_ST_AVG;
                    end
                end
                SDF_ST_AVG: begin
                    dif1 <= int3;
                    dif2 <= comb1;
                    dif3 <= comb2;
                    dly3 <= comb3;
                    chop_phase <= ~chop_phase;
                    avg_sum <= avg_done ? '0 : avg_next;
                    avg_cnt <= avg_done ? 6'd0 : avg_cnt + 6'd1;
                    if (avg_done) begin
                        res_hold <= final_res;
                        prev_out <= avg_res;
                        fsm <= SDF_ST_EMIT;
                    end else begin
                        fsm <= SDF_ST_INTEG;
                    end
                end
                SDF_ST_EMIT: begin
                    o_RESULT_VLD <= 1'b1;
                    fsm <= SDF_ST_INTEG;
                end
            endcase
        end
    end

    // result moves only together with the valid pulse; a restart keeps the last one standing
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            o_RESULT <= '0;
        end else if (i_CE && !restart && fsm == SDF_ST_EMIT) begin
            o_RESULT <= res_hold;
        end
    end

    // ************************************************************
    // comparator, counters and accumulator
    // ************************************************************
    // these follow o_RESULT_VLD only, so power mode never disables them
    wire [15:0] res_mag = mag16(o_RESULT);
    wire above = res_mag >= thresh;
    wire cmp_hit = cmp_mode == SDF_CMP_ON && res_mag > thresh;
    wire [7:0] thv_up = (thv == 8'hff) ? thv : thv + 8'd1;
    wire [7:0] thv_dn = (cmp_mode == SDF_CMP_CNT_CLR || thv == 8'h00) ? 8'h00 : thv - 8'd1;
    wire [7:0] next_thv = above ? thv_up : thv_dn;
    wire cnt_mode = cmp_mode == SDF_CMP_CNT_DEC || cmp_mode == SDF_CMP_CNT_CLR;
    wire thc_hit = cnt_mode && next_thv == tcl;
    wire rc_wrap = rcv + 16'd1 >= rcl;
    wire rc_hit = rc_en && rc_wrap;
    wire [31:0] res_sx = {{16{o_RESULT[15]}}, o_RESULT};
    wire [31:0] next_acc = acc_mode == SDF_ACC_SUB ? acc - res_sx :
                           acc_mode == SDF_ACC_ABS ? acc + {16'h0000, res_mag} : acc + res_sx;

    // peripheral counters
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            thv <= '0;
            rcv <= '0;
            acc <= '0;
        end else if (i_CE) begin
            if (reconfig) begin
                rcv <= '0;
                acc <= '0;
                thv <= '0;
            end else begin
                if (acc_mode == SDF_ACC_OFF) acc <= '0;
                else if (o_RESULT_VLD) acc <= next_acc;
                if (!cnt_mode) thv <= '0;
                else if (o_RESULT_VLD) thv <= next_thv;
                if (o_RESULT_VLD && rc_en) rcv <= rc_wrap ? 16'd0 : rcv + 16'd1;
            end
        end
    end

    // sticky status; event wins over a same-cycle clear; irq gated by result counter when enabled
    wire gate_ok = !rc_en || rc_hit;
    wire [3:0] ev = o_RESULT_VLD ? {1'b1, rc_hit, thc_hit && gate_ok, cmp_hit && gate_ok} : 4'h0;
    wire [3:0] next_status = (status & ~(wr_status ? i_WDATA[3:0] : 4'h0)) | ev;
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            status <= '0;
            o_IRQ <= 1'b0;
        end else if (i_CE) begin
            status <= next_status;
            o_IRQ <= |next_status[`SDF_ST_RC:`SDF_ST_CMP];
        end
    end

    // ************************************************************
    // analog controls and read port
    // ************************************************************
    wire [9:0] next_gain = pwr == SDF_PWR_LOWPLUS ? `SDF_GAIN_LPP :
                           pwr == SDF_PWR_LOW ? `SDF_GAIN_LP : i_GAIN_PROG;
    wire [31:0] rd_mux = i_ADDR == `SDF_OFF_FILTER ? {16'h0000, filter_cfg} :
                         i_ADDR == `SDF_OFF_MODE ? {24'h000000, mode_reg} :
                         i_ADDR == `SDF_OFF_FEATURE ? {24'h000000, feature_cfg} :
                         i_ADDR == `SDF_OFF_THRESH ? {16'h0000, thresh} :
                         i_ADDR == `SDF_OFF_TCL ? {24'h000000, tcl} :
                         i_ADDR == `SDF_OFF_THV ? {24'h000000, thv} :
                         i_ADDR == `SDF_OFF_ACC ? acc :
                         i_ADDR == `SDF_OFF_RCL ? {16'h0000, rcl} :
                         i_ADDR == `SDF_OFF_RCV ? {16'h0000, rcv} :
                         i_ADDR == `SDF_OFF_STATUS ? {28'h0000000, status} : 32'h00000000;

    // outputs registered; read data valid one cycle after the strobe only
    always_ff @(posedge I_CLOCK) begin
        if (I_SYS_RST) begin
            o_RDATA <= '0;
            o_PWR_MODE <= SDF_PWR_NORMAL;
            o_REF_LOWPOWER <= 1'b0;
            o_LP_CLK_SEL <= 1'b0;
            o_GAIN <= '0;
        end else if (i_CE) begin
            o_RDATA <= i_RD ? rd_mux : 32'h00000000;
            o_PWR_MODE <= pwr;
            o_REF_LOWPOWER <= mode_reg[`SDF_MDE_REF];
            o_LP_CLK_SEL <= pwr != SDF_PWR_NORMAL;
            o_GAIN <= next_gain;
        end
    end
endmodule // sdf_filter_top

/* File: hdl/sdf_consts.svh */
// constant definitions for the sigma-delta filter and comparator block
`ifndef SDF_CONSTS_SVH
`define SDF_CONSTS_SVH
// register offsets (word indices on the plain port)
`define SDF_OFF_FILTER 4'h0
`define SDF_OFF_MODE 4'h1
`define SDF_OFF_FEATURE 4'h2
`define SDF_OFF_THRESH 4'h3
`define SDF_OFF_TCL 4'h4
`define SDF_OFF_THV 4'h5
`define SDF_OFF_ACC 4'h6
`define SDF_OFF_RCL 4'h7
`define SDF_OFF_RCV 4'h8
`define SDF_OFF_STATUS 4'h9
// reset values
`define SDF_RST_FILTER 16'h0007
`define SDF_RST_MODE 8'h00
`define SDF_RST_FEATURE 8'h00
`define SDF_RST_THRESH 16'h0000
`define SDF_RST_TCL 8'h01
`define SDF_RST_RCL 16'h0001
// field positions
`define SDF_FLT_DEC_HI 6
`define SDF_FLT_DEC_LO 0
`define SDF_FLT_MOD 7
`define SDF_FLT_AVG_HI 13
`define SDF_FLT_AVG_LO 8
`define SDF_FLT_RAVG 14
`define SDF_FLT_CHOP 15
`define SDF_MDE_PWR_HI 4
`define SDF_MDE_PWR_LO 3
`define SDF_MDE_REF 5
`define SDF_CFG_RCEN 0
`define SDF_CFG_CMP_HI 4
`define SDF_CFG_CMP_LO 3
`define SDF_CFG_ACC_HI 6
`define SDF_CFG_ACC_LO 5
// status bits
`define SDF_ST_CMP 0
`define SDF_ST_THC 1
`define SDF_ST_RC 2
`define SDF_ST_RDY 3
// fixed gains
`define SDF_GAIN_LP 10'd128
`define SDF_GAIN_LPP 10'd512
// base decimation: 512 kHz modulator / 64 = 8 kHz max rate
`define SDF_BASE_DEC 8'd64
`endif

/* File: hdl/sdf_pkg.sv */
// types shared by the sigma-delta filter and comparator block
package sdf_pkg;
    typedef enum logic [1:0] {SDF_PWR_NORMAL = 2'b00, SDF_PWR_LOW = 2'b01, SDF_PWR_LOWPLUS = 2'b10,
                              SDF_PWR_RSVD = 2'b11} sdf_pwr_t;
    typedef enum logic [1:0] {SDF_CMP_OFF = 2'b00, SDF_CMP_ON = 2'b01, SDF_CMP_CNT_DEC = 2'b10,
                              SDF_CMP_CNT_CLR = 2'b11} sdf_cmp_t;
    typedef enum logic [1:0] {SDF_ACC_OFF = 2'b00, SDF_ACC_ADD = 2'b01, SDF_ACC_SUB = 2'b10,
                              SDF_ACC_ABS = 2'b11} sdf_acc_t;
    typedef enum logic [2:0] {SDF_ST_INTEG = 3'b001, SDF_ST_AVG = 3'b010, SDF_ST_EMIT = 3'b100} sdf_fsm_t;
endpackage

/* File: test/sdf_filter_top_properties.sv */
// port assertions for the sigma-delta filter block
`include "sdf_consts.svh"
module sdf_checker #(parameter int DATA_W = 24) (
    // clock, reset, enable
    input wire logic I_CLOCK,
    input wire logic I_SYS_RST,
    input wire logic i_CE,
    // register port
    input wire logic [3:0] i_ADDR,
    input wire logic [31:0] i_WDATA,
    input wire logic i_WR,
    input wire logic i_RD,
    input wire logic [31:0] o_RDATA,
    // stream and analog side
    input wire logic i_MOD_BIT,
    input wire logic i_MOD_STB,
    input wire sdf_pkg::sdf_pwr_t o_PWR_MODE,
    input wire logic o_REF_LOWPOWER,
    input wire logic o_LP_CLK_SEL,
    input wire logic [9:0] o_GAIN,
    input wire logic [9:0] i_GAIN_PROG,
    input wire logic [15:0] o_RESULT,
    input wire logic o_RESULT_VLD,
    input wire logic o_IRQ
);
    timeunit 1ns;
    timeprecision 100ps;
    import sdf_pkg::*;
    // ****************
    // port rules
    // ****************
    default clocking cb @(posedge I_CLOCK); endclocking
    default disable iff (I_SYS_RST);
    // valid falls right after it rises
    sequence vld_drop_s;
        1 ##1 !o_RESULT_VLD;
    endsequence
    // gain is judged only once the mode has settled for two cycles
    sequence held_s(sdf_pwr_t m);
        (i_CE && o_PWR_MODE == m) [*2];
    endsequence
    rd_idle_a: assert property (i_CE && !i_RD |=> o_RDATA == 32'h0)
        else $error("read data without read");
    vld_pulse_a: assert property (o_RESULT_VLD && i_CE |-> vld_drop_s) else $error("valid too long");
    res_hold_a: assert property (!o_RESULT_VLD |-> $stable(o_RESULT))
        else $error("result moved without valid");
    vld_cause_a: assert property (o_RESULT_VLD |-> $past(i_MOD_STB, 2) || $past(i_MOD_STB, 3))
        else $error("result without strobe");
    gain_lpp_a: assert property (held_s(SDF_PWR_LOWPLUS) |-> o_GAIN == 10'd512) else $error("gain not 512");
    gain_lp_a: assert property (held_s(SDF_PWR_LOW) |-> o_GAIN == 10'd128) else $error("gain not 128");
    gain_norm_a: assert property (held_s(SDF_PWR_NORMAL) |-> o_GAIN == $past(i_GAIN_PROG))
        else $error("gain not programmed value");
    clk_sel_a: assert property (o_LP_CLK_SEL == (o_PWR_MODE != SDF_PWR_NORMAL)) else $error("clock select");
    irq_hold_a: assert property (o_IRQ && !(i_WR && i_ADDR == `SDF_OFF_STATUS) |=> o_IRQ)
        else $error("interrupt dropped");
    irq_cause_a: assert property ($rose(o_IRQ) |-> $past(o_RESULT_VLD) || $past(o_RESULT_VLD, 2))
        else $error("interrupt without result");
endmodule // sdf_checker
bind sdf_filter_top sdf_checker #(.DATA_W(DATA_W)) sdf_checker_inst (.*);

/* File: test/sdf_mod_src.sv */
// behavioural modulator bit stream feeding the filter
module sdf_mod_src (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // bench control
    input wire logic i_run,
    input wire logic i_slow,
    input wire logic i_ones,
    // bit stream
    output logic o_bit,
    output logic o_stb
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****************
    // stream generator
    // ****************
    logic [2:0] cnt = 3'h0;
    logic fire;
    assign fire = i_run && (i_slow ? cnt == 3'h7 : cnt[1:0] == 2'h3);
    initial o_bit = 1'b0;
    initial o_stb = 1'b0;
    // period of 4 or 8 keeps the valid delay clear of the next bit;
    // off-strobe the line inverts, so sampling there reads nonsense
    always @(posedge clk) begin
        cnt <= rst ? 3'h0 : cnt + 3'h1;
        o_stb <= !rst && fire;
        o_bit <= fire ? i_ones | 1'($urandom) : ~o_bit;
    end
endmodule // sdf_mod_src

/* File: test/tb_sdf_filter_top.sv */
// self-checking bench for the sigma-delta filter block
`include "sdf_consts.svh"
module tb_sdf_filter_top;
    timeunit 1ns;
    timeprecision 100ps;
    import sdf_pkg::*;
    // ****************
    // stimulus and model
    // ****************
    logic clk = 1'b0, rst = 1'b1, wstb = 1'b0, rstb = 1'b0, run = 1'b0, slow = 1'b0, ones = 1'b0, ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [31:0] wdata = 32'h0, rdata, acc = 32'h0;
    logic [9:0] gprog = 10'h0, gain;
    logic [15:0] res;
    logic mbit, mstb, vld, irq, refl, lpsel;
    sdf_pwr_t pmode;
    logic [15:0] flt [5] = '{16'h0000, 16'h0007, 16'h0087, 16'h4000, 16'h0103};
    logic [15:0] fv [3] = '{16'h961f, 16'hbf1d, 16'hbd1f};
    int n_errors = 0, compares = 0, nstb = 0, last = 0, ivl = 0, nres = 0;
    int rcv = 0, thv = 0, st = 0, feat = 0, th = 0, tcl = 1, rcl = 1, r, mag, v;
    bit wrap;
    always #12.5 clk = ~clk;
    sdf_mod_src sdf_mod_src_inst (.clk(clk), .rst(rst), .i_run(run), .i_slow(slow), .i_ones(ones),
        .o_bit(mbit), .o_stb(mstb));
    sdf_filter_top sdf_filter_top_inst (.I_CLOCK(clk), .I_SYS_RST(rst), .i_CE(ce), .i_ADDR(addr),
        .i_WDATA(wdata), .i_WR(wstb), .i_RD(rstb), .o_RDATA(rdata), .i_MOD_BIT(mbit), .i_MOD_STB(mstb),
        .o_PWR_MODE(pmode), .o_REF_LOWPOWER(refl), .o_LP_CLK_SEL(lpsel), .o_GAIN(gain),
        .i_GAIN_PROG(gprog), .o_RESULT(res), .o_RESULT_VLD(vld), .o_IRQ(irq));
    // reference model, one step per reported result
    always @(posedge clk) begin
        if (mstb) nstb++;
        if (!rst && vld) begin
            nres++;
            ivl = nstb - last;
            last = nstb;
            r = $signed(res);
            mag = r < 0 ? -r : r;
            wrap = rcv + 1 >= rcl;
            if (feat[0]) rcv = wrap ? 0 : rcv + 1;
            if (feat[0] && wrap) st |= 4;
            if (feat[4:3] == 1 && (!feat[0] || wrap) && mag > th) st |= 1;
            if (feat[4]) thv = mag >= th ? thv + 1 : feat[3] || thv == 0 ? 0 : thv - 1;
            if (feat[4] && (!feat[0] || wrap) && thv == tcl) st |= 2;
            acc = feat[6:5] == 0 ? 0 : feat[6:5] == 1 ? acc + r : feat[6:5] == 2 ? acc - r : acc + mag;
        end
    end
    task automatic conclude();
        if (n_errors == 0 && compares > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_errors++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // one-cycle strobes; a writes to mode or feature also resets the model counters
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
        if (a == 1 || a == 2) {rcv, thv, acc} = 0;
        if (a == 2) feat = d;
        if (a == 3) th = d;
        if (a == 4) tcl = d;
        if (a == 7) rcl = d;
        if (a == 9) st &= ~d;
        @(posedge clk);
    endtask
    task automatic rchk(input logic [3:0] a, input logic [31:0] exp, input logic [31:0] m = '1);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        @(negedge clk);
        chk(rdata & m, exp);
        @(posedge clk);
    endtask
    task automatic run_res(input int n);
        int goal;
        int t;
        goal = nres + n;
        run <= 1'b1;
        for (t = 0; t < n * 5000 && nres < goal; t++) @(posedge clk);
        run <= 1'b0;
        if (nres < goal) begin
            n_errors++;
            conclude();
        end
        repeat (4) @(posedge clk);
    endtask
    task automatic audit();
        rchk(`SDF_OFF_STATUS, st, 7);
        chk(irq, st != 0);
        rchk(`SDF_OFF_ACC, acc);
        if (feat[4]) rchk(`SDF_OFF_THV, thv);
        if (feat[0]) rchk(`SDF_OFF_RCV, rcv);
    endtask
    initial begin
        void'($urandom(83));
        repeat (8) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        for (int a = 0; a < 16; a++) rchk(a, a == 0 ? 7 : a == 4 || a == 7 ? 1 : 0, a == 9 ? 7 : '1);
        foreach (fv[i]) begin
            wr_reg(`SDF_OFF_FILTER, fv[i]);
            rchk(`SDF_OFF_FILTER, fv[i]);
        end
        v = $urandom;
        wr_reg(`SDF_OFF_FILTER, v);
        rchk(`SDF_OFF_FILTER, v & 16'hffff);
        // frozen clock enable: this write must not land
        ce <= 1'b0;
        wr_reg(`SDF_OFF_FILTER, ~v);
        ce <= 1'b1;
        rchk(`SDF_OFF_FILTER, v & 16'hffff);
        wr_reg(4'hc, $urandom);
        rchk(4'hc, 0);
        for (int m = 0; m < 6; m++) begin
            gprog <= $urandom;
            v = (m % 3) << 3 | (m / 3) << 5;
            wr_reg(`SDF_OFF_MODE, v);
            @(negedge clk);
            chk(pmode, m % 3);
            chk(refl, m / 3);
            chk(lpsel, m % 3 != 0);
            chk(gain, m % 3 == 2 ? 512 : m % 3 ? 128 : gprog);
            @(posedge clk);
            rchk(`SDF_OFF_MODE, v);
        end
        // rate in strobes between the second and third result, any power mode
        foreach (flt[i]) begin
            wr_reg(`SDF_OFF_MODE, (i % 3) << 3);
            wr_reg(`SDF_OFF_FILTER, flt[i]);
            slow <= 1'($urandom);
            run_res(3);
            chk(ivl, (flt[i][6:0] + 1) * 64 * (flt[i][13:8] + 1));
        end
        // fastest setting keeps the event scenarios well inside the cycle budget
        slow <= 1'b0;
        wr_reg(`SDF_OFF_FILTER, 0);
        wr_reg(`SDF_OFF_RCL, 3);
        wr_reg(`SDF_OFF_TCL, 2);
        wr_reg(`SDF_OFF_FEATURE, 32'h21);
        run_res(2);
        audit();
        run_res(1);
        audit();
        wr_reg(`SDF_OFF_STATUS, 7);
        audit();
        run_res(1);
        wr_reg(`SDF_OFF_MODE, 0);
        audit();
        for (int k = 0; k < 9; k++) begin
            wr_reg(`SDF_OFF_MODE, ((k + 1) % 3) << 3);
            wr_reg(`SDF_OFF_FEATURE, (k / 3 + 1) << 5 | (k % 3 + 1) << 3);
            wr_reg(`SDF_OFF_THRESH, $urandom % 32'h1000);
            ones <= 1'($urandom);
            run_res(2);
            audit();
            wr_reg(`SDF_OFF_STATUS, 7);
        end
        conclude();
    end
endmodule // tb_sdf_filter_top
